// ==== src/qrbs_ctrl.sv ====
// Purpose: Memory controller end of the quad rate burst port
// Assumes: Device reset together with this end
// Notes:   Makes the link clock pair by dividing core_clk
`timescale 1ns/1ps
`default_nettype none
module qrbs_ctrl
    import qrbs_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // Configuration
    input  wire logic              long_latency,
    // Write requests
    input  wire logic              wr_valid,
    output logic                   wr_ready,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [WBUF_W-1:0] wr_data,
    // Read requests
    input  wire logic              rd_valid,
    output logic                   rd_ready,
    input  wire logic [ADDR_W-1:0] rd_addr,
    // Read return
    output logic [WORD_W-1:0]      rd_data,
    output logic                   rd_data_valid,
    // Link to the device
    qrbs_if.ctl                    link
);
    typedef struct packed {
        logic [CNT_W-1:0]       cnt;
        logic                   k;
        logic                   k_n;
        logic                   phase;
        logic [ADDR_W-1:0]      addr;
        logic                   rd_sel_n;
        logic                   wr_sel_n;
        logic [WORD_W-1:0]      d;
        logic                   mode;
        logic [WBUF_W-1:0]      wbuf;
        logic [2:0]             wleft;
        logic                   rd_ready;
        logic [2:0]             e_s;
        logic [2:0]             en_s;
        logic [1:0]             v_s;
        logic [1:0][WORD_W-1:0] q_s;
        logic [WORD_W-1:0]      rd_data;
        logic                   rd_data_valid;
    } qrbs_ctl_st_type;

    qrbs_ctl_st_type   st_ff;
    qrbs_ctl_st_type   nxt_st;
    logic              f_valid;
    logic              f_ready;
    logic [FIFO_W-1:0] f_data;
    logic              launch;
    logic              up_rise;
    logic [2:0]        beat;

    // ****************************************
    // Write burst queue
    // ****************************************
    qrbs_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_wfifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   ({wr_addr, wr_data}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    assign link.k                = st_ff.k;
    assign link.k_n              = st_ff.k_n;
    assign link.addr             = st_ff.addr;
    assign link.rd_sel_n         = st_ff.rd_sel_n;
    assign link.wr_sel_n         = st_ff.wr_sel_n;
    assign link.d                = st_ff.d;
    assign link.latency_mode_pin = st_ff.mode;
    assign rd_ready              = st_ff.rd_ready;
    assign rd_data               = st_ff.rd_data;
    assign rd_data_valid         = st_ff.rd_data_valid;

    // Pins change mid half-period, far from the clock edge
    assign launch  = (st_ff.cnt == LAUNCH_CNT);
    assign up_rise = !st_ff.k;
    assign beat    = 3'(BURST) - st_ff.wleft;
    // Pop only in a write slot, in the launch that sends the last beat or later
    assign f_ready = launch && up_rise && st_ff.phase
                     && (st_ff.wleft <= 3'h1);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.mode = long_latency;
        // Divider makes the clock pair, complement kept exact
        nxt_st.cnt  = st_ff.cnt + 1'b1;
        if (st_ff.cnt == CNT_LAST) begin
            nxt_st.cnt = '0;
            nxt_st.k   = !st_ff.k;
            nxt_st.k_n = st_ff.k;
            if (!st_ff.k) begin
                nxt_st.phase = !st_ff.phase;
            end
        end
        // Offer the read slot in its launch cycle, set one cycle ahead
        nxt_st.rd_ready = (st_ff.cnt == READY_CNT) && !st_ff.k
                          && !st_ff.phase;
        if (launch) begin
            nxt_st.rd_sel_n = 1'b1;
            nxt_st.wr_sel_n = 1'b1;
            if (st_ff.wleft != '0) begin
                nxt_st.d     = st_ff.wbuf[beat[1:0]*WORD_W +: WORD_W];
                nxt_st.wleft = st_ff.wleft - 1'b1;
            end
            if (up_rise && !st_ff.phase && st_ff.rd_ready
                && rd_valid) begin
                nxt_st.addr     = rd_addr;
                nxt_st.rd_sel_n = 1'b0;
            end
            if (f_ready && f_valid) begin
                nxt_st.addr     = f_data[FIFO_W-1 -: ADDR_W];
                nxt_st.wbuf     = f_data[WBUF_W-1:0];
                nxt_st.wr_sel_n = 1'b0;
                nxt_st.wleft    = 3'(BURST);
            end
        end
        // Return pins cross into core_clk through two flops
        nxt_st.e_s  = {st_ff.e_s[1:0], link.echo_strobe};
        nxt_st.en_s = {st_ff.en_s[1:0], link.echo_strobe_n};
        nxt_st.v_s  = {st_ff.v_s[0], link.read_valid_flag};
        nxt_st.q_s  = {st_ff.q_s[0], link.q};
        nxt_st.rd_data_valid = 1'b0;
        if (((st_ff.e_s[1] && !st_ff.e_s[2])
             || (st_ff.en_s[1] && !st_ff.en_s[2])) && st_ff.v_s[1]) begin
            nxt_st.rd_data       = st_ff.q_s[1];
            nxt_st.rd_data_valid = 1'b1;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_ff          <= '0;
            st_ff.k_n      <= 1'b1;
            st_ff.rd_sel_n <= 1'b1;
            st_ff.wr_sel_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

// ==== src/qrbs_device.sv ====
// Purpose: Burst SRAM end of the quad rate burst port
// Assumes: Link clock half-period spans several core cycles
// Notes:   Link pins are sampled by core_clk through two flops
//
// Functional notes
// R1: Separate read outputs and write inputs
// R2: Shared address; read, write on alternate edges
// R3: One address selects four words in sequence
// R4: One word per rising edge of either clock
// R5: Only rising edges of the clock pair act
// R6: Mode high: read data 2.5 cycles later
// R7: Mode low: read data one cycle later
// R8: Valid flag marks phases carrying read data
// R9: Echo strobe pair travels with read data
// R10: Port selects gate read and write apart
// R11: Read and write run independently, same period
// R12: All inputs registered before use
// R13: Read data launched from output registers
// R14: Writes complete internally, no write pulse
// R15: Read of a pending write returns newest data
// R16: Burst beats generated from one base address
`timescale 1ns/1ps
`default_nettype none
module qrbs_device
    import qrbs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Link to the controller
    qrbs_if.dev      link
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        // Input synchronisers, index 0 is the first flop
        logic [2:0]                    k_s;
        logic [2:0]                    kn_s;
        logic [1:0][ADDR_W-1:0]        a_s;
        logic [1:0]                    rs_s;
        logic [1:0]                    ws_s;
        logic [1:0][WORD_W-1:0]        d_s;
        logic [1:0]                    m_s;
        // Address slot tracking and write burst
        logic                          phase;
        logic                          wact;
        logic [BEAT_W-1:0]             widx;
        logic [ADDR_W-1:0]             waddr;
        // Read output schedule, entry 0 is due now
        qrbs_slot_type [PIPE_D-1:0]    pipe;
        // Output registers
        logic [WORD_W-1:0]             q;
        logic                          qv;
        logic                          echo;
        logic                          echo_n;
    } qrbs_dev_st_type;

    qrbs_dev_st_type             st_ff;
    qrbs_dev_st_type             nxt_st;
    logic [WORD_W-1:0]           mem [0:MEM_D-1];
    logic                        k_rise;
    logic                        kn_rise;
    logic                        edge_any;
    logic                        we;
    logic [ADDR_W+BEAT_W-1:0]    w_index;
    logic [ADDR_W+BEAT_W-1:0]    r_index;
    int                          lat;

    // ****************************************
    // Output pins
    // ****************************************
    // Every read pin is a flop, so no glitch reaches the link
    assign link.q               = st_ff.q;             // R13
    assign link.read_valid_flag = st_ff.qv;            // R8
    assign link.echo_strobe     = st_ff.echo;          // R9
    assign link.echo_strobe_n   = st_ff.echo_n;        // R9

    // Rising edges only, seen on the second sync stage
    assign k_rise   = st_ff.k_s[1] && !st_ff.k_s[2];   // R5
    assign kn_rise  = st_ff.kn_s[1] && !st_ff.kn_s[2]; // R5
    assign edge_any = k_rise || kn_rise;               // R4

    // Write and read word addresses in the flat array
    assign w_index = {st_ff.waddr, st_ff.widx};

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_st  = st_ff;
        we      = 1'b0;
        r_index = '0;
        lat     = st_ff.m_s[1] ? LAT_LONG : LAT_SHORT; // R6 R7

        // Every pin passes two flops before it is used
        nxt_st.k_s  = {st_ff.k_s[1:0], link.k};           // R12
        nxt_st.kn_s = {st_ff.kn_s[1:0], link.k_n};        // R12
        nxt_st.a_s  = {st_ff.a_s[0], link.addr};          // R12
        nxt_st.rs_s = {st_ff.rs_s[0], link.rd_sel_n};     // R12
        nxt_st.ws_s = {st_ff.ws_s[0], link.wr_sel_n};     // R12
        nxt_st.d_s  = {st_ff.d_s[0], link.d};             // R12
        nxt_st.m_s  = {st_ff.m_s[0], link.latency_mode_pin};

        if (edge_any) begin
            // Read schedule advances one slot per data edge
            for (int i = 0; i < PIPE_D - 1; i++) begin
                nxt_st.pipe[i] = st_ff.pipe[i + 1];
            end
            nxt_st.pipe[PIPE_D-1] = '0;

            // Write beat lands in the array on this edge
            if (st_ff.wact) begin
                we          = 1'b1;                        // R14
                nxt_st.widx = st_ff.widx + 1'b1;           // R16
                if (st_ff.widx == BEAT_W'(BURST - 1)) begin
                    nxt_st.wact = 1'b0;                    // R3
                end
            end

            // Address slots alternate on rising true edges
            if (k_rise) begin
                nxt_st.phase = !st_ff.phase;               // R2
                // Read slot: book four beats after the latency
                if (!st_ff.phase && !st_ff.rs_s[1]) begin  // R10 R11
                    for (int b = 0; b < BURST; b++) begin
                        nxt_st.pipe[lat + b].v = 1'b1;     // R3
                        nxt_st.pipe[lat + b].a = st_ff.a_s[1];
                        nxt_st.pipe[lat + b].b = BEAT_W'(b); // R16
                    end
                end
                // Write slot: data follows on the next four edges
                if (st_ff.phase && !st_ff.ws_s[1]) begin   // R10 R11
                    nxt_st.waddr = st_ff.a_s[1];           // R2
                    nxt_st.wact  = 1'b1;
                    nxt_st.widx  = '0;
                end
            end

            // Launch the due beat; a beat written now wins
            nxt_st.qv = nxt_st.pipe[0].v;                  // R8
            if (nxt_st.pipe[0].v) begin
                r_index = {nxt_st.pipe[0].a, nxt_st.pipe[0].b};
                if (we && (w_index == r_index)) begin
                    nxt_st.q = st_ff.d_s[1];               // R15
                end else begin
                    nxt_st.q = mem[r_index];               // R13
                end
            end

            // Echo pair copies which clock made this edge
            nxt_st.echo   = k_rise;                        // R9
            nxt_st.echo_n = kn_rise;                       // R9
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    // Control state resets; the array itself holds no reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_ff      <= '0;
            st_ff.kn_s <= '1; // k_n idles high: no false edge
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Self-timed write: the beat is stored with no strobe pin
    always_ff @(posedge core_clk) begin
        if (rst_n && we) begin
            mem[w_index] <= st_ff.d_s[1];                 // R1 R14
        end
    end
endmodule
`default_nettype wire

// ==== src/qrbs_fifo.sv ====
// Purpose: Small valid/ready FIFO for queued write bursts
// Assumes: Same clock on both sides
// Notes:   in_ready comes from a flop, so it lags a pop by one cycle
`timescale 1ns/1ps
`default_nettype none
module qrbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] PLAST = PW'(DEPTH - 1);
    localparam logic [PW:0]   CFULL = (PW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
        logic                        not_full;
    } qrbs_fifo_st_type;

    qrbs_fifo_st_type st_ff;
    qrbs_fifo_st_type nxt_st;
    logic             push;
    logic             pop;

    assign out_valid = (st_ff.cnt != '0);
    assign out_data  = st_ff.mem[st_ff.rp];
    assign in_ready  = st_ff.not_full;

    // ****************************************
    // Pointer and count update
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        push   = in_valid && st_ff.not_full;
        pop    = out_valid && out_ready;
        if (push) begin
            nxt_st.mem[st_ff.wp] = in_data;
            nxt_st.wp = (st_ff.wp == PLAST) ? '0 : st_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_st.rp = (st_ff.rp == PLAST) ? '0 : st_ff.rp + 1'b1;
        end
        if (push && !pop) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
        nxt_st.not_full = (nxt_st.cnt != CFULL);
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_ff          <= '0;
            st_ff.not_full <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

// ==== src/qrbs_if.sv ====
// Purpose: Pins between the burst SRAM and its controller
// Assumes: All pins are one-way; no tristate is needed
// Notes:   Controller drives the link clock pair
`timescale 1ns/1ps
`default_nettype none
interface qrbs_if;
    import qrbs_pkg::*;
    // Clock pair and command
    logic              k;
    logic              k_n;
    logic [ADDR_W-1:0] addr;
    logic              rd_sel_n;
    logic              wr_sel_n;
    logic [WORD_W-1:0] d;
    logic              latency_mode_pin;
    // Read return
    logic [WORD_W-1:0] q;
    logic              read_valid_flag;
    logic              echo_strobe;
    logic              echo_strobe_n;

    modport dev (
        input  k, k_n, addr, rd_sel_n, wr_sel_n, d, latency_mode_pin,
        output q, read_valid_flag, echo_strobe, echo_strobe_n
    );
    modport ctl (
        output k, k_n, addr, rd_sel_n, wr_sel_n, d, latency_mode_pin,
        input  q, read_valid_flag, echo_strobe, echo_strobe_n
    );
endinterface
`default_nettype wire

// ==== src/qrbs_pkg.sv ====
// Purpose: Shared constants for the quad rate burst SRAM port
// Assumes: Core clock 200 MHz; link clock made by the controller
// Notes:   x18 word width, small array depth for simulation
package qrbs_pkg;
    // ****************************************
    // Data path sizes
    // ****************************************
    localparam int WORD_W = 18;              // x18 configuration
    localparam int ADDR_W = 6;               // Burst address width
    localparam int BURST  = 4;               // Words per address
    localparam int BEAT_W = 2;               // Beat index width
    localparam int MEM_D  = BURST << ADDR_W; // Words in the array
    localparam int WBUF_W = WORD_W * BURST;  // One whole write burst
    localparam int FIFO_W = ADDR_W + WBUF_W;
    localparam int FIFO_D = 4;

    // ****************************************
    // Read latency in link half-periods
    // ****************************************
    localparam int LAT_LONG  = 5;            // 2.5 link cycles
    localparam int LAT_SHORT = 2;            // 1 link cycle
    localparam int PIPE_D    = LAT_LONG + BURST;

    // ****************************************
    // Link clock timing
    // ****************************************
    localparam int CORE_MHZ     = 200;
    localparam int LINK_HALF_NS = 25;
    localparam int K_HALF = LINK_HALF_NS * CORE_MHZ / 1000;
    localparam int CNT_W  = 3;
    localparam logic [CNT_W-1:0] CNT_LAST   = CNT_W'(K_HALF - 1);
    localparam logic [CNT_W-1:0] LAUNCH_CNT = 3'h1;
    localparam logic [CNT_W-1:0] READY_CNT  = 3'h0;

    // Read slot entry in the device output schedule
    typedef struct packed {
        logic              v;
        logic [ADDR_W-1:0] a;
        logic [BEAT_W-1:0] b;
    } qrbs_slot_type;
endpackage

// ==== testbench/qrbs_link_properties.sv ====
// Purpose: Timing checks on the link between the two ends
// Assumes: Link clock made by the controller, 5 core cycles a phase
// Notes:   Sees the interface signals only
`timescale 1ns/1ps
`default_nettype none
module qrbs_link_properties
    import qrbs_pkg::*;
(
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              rst_n,
    // Controller to device
    input wire logic              k,
    input wire logic              k_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              rd_sel_n,
    input wire logic              wr_sel_n,
    input wire logic [WORD_W-1:0] d,
    input wire logic              latency_mode_pin,
    // Device to controller
    input wire logic [WORD_W-1:0] q,
    input wire logic              read_valid_flag,
    input wire logic              echo_strobe,
    input wire logic              echo_strobe_n
);
    typedef struct packed {
        logic        kq;    // Link clock one core cycle ago
        logic        kph;   // Slot of the next k rise: 0 read, 1 write
        logic [7:0]  ridle; // Cycles since the last read capture
        logic [15:0] vlen;  // Cycles the valid flag has stood high
    } qrbs_chk_state_type;

    qrbs_chk_state_type st_ff;
    qrbs_chk_state_type nxt_st;

    // Slot tracking; ridle lets latency checks skip overlapping bursts
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.kq   = k;
        nxt_st.vlen = read_valid_flag ? st_ff.vlen + 16'h0001 : 16'h0000;
        if (k && !st_ff.kq) begin
            nxt_st.kph = !st_ff.kph;
        end
        if (k && !st_ff.kq && !st_ff.kph && !rd_sel_n) begin
            nxt_st.ridle = 8'h00;
        end else if (st_ff.ridle != 8'hFF) begin
            nxt_st.ridle = st_ff.ridle + 8'h01;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // Link assertions
    // ****************************************
    chk_clock_pair: assert property (k_n == ~k)
        else $error("link clock pair not complementary");
    chk_half_period: assert property ($rose(k) |-> k [*5] ##1 !k)
        else $error("link clock half period wrong");
    chk_read_slot: assert property ($rose(k) && st_ff.kph |-> rd_sel_n)
        else $error("read select in write slot");
    chk_write_slot: assert property ($rose(k) && !st_ff.kph |-> wr_sel_n)
        else $error("write select in read slot");
    chk_long_lat: assert property ($rose(k) && !st_ff.kph && !rd_sel_n &&
        st_ff.ridle > 8'h32 && latency_mode_pin
        |-> ##[27:29] $rose(read_valid_flag))
        else $error("long read latency wrong");
    chk_short_lat: assert property ($rose(k) && !st_ff.kph && !rd_sel_n &&
        st_ff.ridle > 8'h32 && !latency_mode_pin
        |-> ##[12:14] $rose(read_valid_flag))
        else $error("short read latency wrong");
    chk_echo_true: assert property ($rose(k) |-> ##[1:4] (echo_strobe && !echo_strobe_n))
        else $error("echo strobe missed k edge");
    chk_echo_comp: assert property ($rose(k_n) |-> ##[1:4] (echo_strobe_n && !echo_strobe))
        else $error("echo strobe missed k_n edge");
    chk_valid_echo: assert property ($changed(read_valid_flag) |-> $changed(echo_strobe))
        else $error("valid flag moved off a link edge");
    chk_valid_len: assert property ($fell(read_valid_flag) |-> st_ff.vlen % (K_HALF * BURST) == 0)
        else $error("valid flag not whole bursts");
endmodule
`default_nettype wire

// ==== testbench/tb_quad_rate_burst_sram_port.sv ====
// Purpose: Self-checking bench for both ends of the burst SRAM port
// Assumes: Controller makes the link clock; one reset for both ends
// Notes:   Reads are scored in order against a model of written words
`timescale 1ns/1ps
`default_nettype none
module tb_quad_rate_burst_sram_port
    import qrbs_pkg::*;
;
    logic              core_clk      = 1'b0;
    logic              rst_n         = 1'b0;
    logic              long_latency  = 1'b0;
    logic              wr_valid      = 1'b0;
    logic              wr_ready;
    logic [ADDR_W-1:0] wr_addr       = '0;
    logic [WBUF_W-1:0] wr_data       = '0;
    logic              rd_valid      = 1'b0;
    logic              rd_ready;
    logic [ADDR_W-1:0] rd_addr       = '0;
    logic [WORD_W-1:0] rd_data;
    logic              rd_data_valid;
    logic [WORD_W-1:0] mem [MEM_D];
    logic [WORD_W-1:0] exp_q [$];
    logic [31:0]       lfsr_ff       = 32'h00011BDA;
    logic              full_seen     = 1'b0;
    int                errors        = 0;
    int                num_checks    = 0;
    int                cyc           = 0;
    // Address ends and a few in between
    logic [ADDR_W-1:0] addr_tab [6]  = '{6'h00, 6'h01, 6'h2A, 6'h3F,
                                         6'h3E, 6'h05};

    qrbs_if link ();

    qrbs_ctrl qrbs_ctrl_inst (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .long_latency  (long_latency),
        .wr_valid      (wr_valid),
        .wr_ready      (wr_ready),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .rd_valid      (rd_valid),
        .rd_ready      (rd_ready),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_data_valid (rd_data_valid),
        .link          (link)
    );

    qrbs_device qrbs_device_inst (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .link     (link)
    );

    qrbs_link_properties qrbs_link_properties_inst (
        .core_clk         (core_clk),
        .rst_n            (rst_n),
        .k                (link.k),
        .k_n              (link.k_n),
        .addr             (link.addr),
        .rd_sel_n         (link.rd_sel_n),
        .wr_sel_n         (link.wr_sel_n),
        .d                (link.d),
        .latency_mode_pin (link.latency_mode_pin),
        .q                (link.q),
        .read_valid_flag  (link.read_valid_flag),
        .echo_strobe      (link.echo_strobe),
        .echo_strobe_n    (link.echo_strobe_n)
    );

    // Core clock, 5 ns period
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check_word(input logic [WORD_W-1:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t read word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Random burst, held until taken; the model is updated up front
    task automatic write_burst(input logic [ADDR_W-1:0] a);
        logic [WBUF_W-1:0] w;
        for (int i = 0; i < BURST; i++) begin
            lfsr_ff = lfsr_next(lfsr_ff);
            w[i*WORD_W +: WORD_W] = lfsr_ff[WORD_W-1:0];
            mem[{a, i[1:0]}] = lfsr_ff[WORD_W-1:0];
        end
        wr_valid <= 1'b1;
        wr_addr  <= a;
        wr_data  <= w;
        @(posedge core_clk);
        while (wr_ready !== 1'b1) begin
            full_seen = 1'b1;
            @(posedge core_clk);
        end
    endtask

    // Read held until a slot is offered; four words noted in beat order
    task automatic read_burst(input logic [ADDR_W-1:0] a);
        rd_valid <= 1'b1;
        rd_addr  <= a;
        @(posedge core_clk);
        while (rd_ready !== 1'b1) begin
            @(posedge core_clk);
        end
        for (int i = 0; i < BURST; i++) begin
            exp_q.push_back(mem[{a, i[1:0]}]);
        end
    endtask

    // One mode: reset, overrun the buffer, then reads beside writes
    task automatic run_phase(input logic m);
        rst_n        <= 1'b0;
        long_latency <= m;
        full_seen     = 1'b0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 6; i++) begin
            write_burst(addr_tab[i]);
        end
        wr_valid <= 1'b0;
        check_flag(full_seen, 1'b1);
        // Drain time covers six bursts at two link cycles each
        repeat (160) @(posedge core_clk);
        read_burst(addr_tab[3]);
        rd_valid <= 1'b0;
        repeat (60) @(posedge core_clk);
        fork
            begin
                for (int i = 0; i < 4; i++) begin
                    write_burst(6'h10 + 6'(i));
                end
                wr_valid <= 1'b0;
            end
            begin
                for (int i = 0; i < 6; i++) begin
                    read_burst(addr_tab[i]);
                end
                rd_valid <= 1'b0;
            end
        join
        repeat (160) @(posedge core_clk);
        for (int i = 0; i < 4; i++) begin
            read_burst(6'h10 + 6'(i));
        end
        rd_valid <= 1'b0;
        for (int i = 0; i < 300 && exp_q.size() != 0; i++) begin
            @(posedge core_clk);
        end
        check_flag(exp_q.size() == 0, 1'b1);
    endtask

    // Score each returned word against the oldest note
    always @(posedge core_clk) begin
        if (rst_n && rd_data_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check_flag(1'b1, 1'b0);
            end else begin
                check_word(rd_data, exp_q.pop_front());
            end
        end
    end

    // Hang guard, well above the two phases together
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            errors++;
            end_of_test();
        end
    end

    // Main sequence: long latency first, then short
    initial begin
        @(posedge core_clk);
        run_phase(1'b1);
        run_phase(1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
